// ===== core/aate_pkg.sv
package aate_pkg;

  // clocking: the 20 MHz timebase is derived from pclk
  localparam int AATE_PCLK_HZ = 40_000_000;
  localparam int AATE_TB_HZ   = 20_000_000;
  localparam int AATE_TB_DIV  = AATE_PCLK_HZ / AATE_TB_HZ;
  localparam logic [3:0] AATE_TB_CNT_MAX = 4'(AATE_TB_DIV - 1);

  // apb register map, byte addresses
  localparam int AATE_PADDR_W = 8;
  localparam logic [7:0] AATE_OFF_CTRL     = 8'h00;
  localparam logic [7:0] AATE_OFF_SRC      = 8'h04;
  localparam logic [7:0] AATE_OFF_SCAN_DIV = 8'h08;
  localparam logic [7:0] AATE_OFF_CONV_DIV = 8'h0c;
  localparam logic [7:0] AATE_OFF_CHAN     = 8'h10;
  localparam logic [7:0] AATE_OFF_BUF_SIZE = 8'h14;
  localparam logic [7:0] AATE_OFF_PRE_CNT  = 8'h18;
  localparam logic [7:0] AATE_OFF_STATUS   = 8'h1c;
  localparam logic [7:0] AATE_OFF_RD_IDX   = 8'h20;
  localparam logic [7:0] AATE_OFF_RD_DATA  = 8'h24;
  localparam logic [7:0] AATE_OFF_WPTR     = 8'h28;

  // field positions in the control, source and conversion divider words
  localparam int AATE_CTRL_GO_BIT   = 0;
  localparam int AATE_CTRL_STOP_BIT = 1;
  localparam int AATE_CTRL_LSB      = 2;
  localparam int AATE_CTRL_MSB      = 18;
  localparam int AATE_SRC_MSB       = 23;
  localparam int AATE_FIRST_DLY_LSB = 16;

  // values after reset
  localparam logic [15:0] AATE_FIRST_DLY_RST = 16'h0003;
  localparam logic [15:0] AATE_SCAN_DIV_RST  = 16'h0014;
  localparam logic [15:0] AATE_CONV_DIV_RST  = 16'h0002;
  localparam logic [15:0] AATE_BUF_SIZE_RST  = 16'h0010;
  localparam logic [15:0] AATE_PRE_CNT_RST   = 16'h0000;
  localparam logic [7:0]  AATE_CHAN_RST      = 8'h01;

  typedef enum logic [1:0] {
    AATE_MODE_CONT   = 2'b00,
    AATE_MODE_FINITE = 2'b01,
    AATE_MODE_REF    = 2'b10
  } aate_mode_t;

  typedef enum logic [2:0] {
    ACQ_IDLE       = 3'b000,
    ACQ_WAIT_BEGIN = 3'b001,
    ACQ_RUN        = 3'b010,
    ACQ_PRE        = 3'b011,
    ACQ_ARMED      = 3'b100,
    ACQ_POST       = 3'b101
  } aate_acq_st_t;

  typedef enum logic [1:0] {
    SC_WAIT  = 2'b00,
    SC_DELAY = 2'b01,
    SC_CONV  = 2'b10
  } aate_scan_st_t;

  // control word bits 18..2, first member is the top bit
  typedef struct packed {
    logic       route_hold;
    logic       route_strobe;
    logic       route_begin;
    logic       route_conv;
    logic       strobe_low;
    logic       scan_tb_ext;
    logic       conv_tb_scan;
    logic       single_clk;
    logic       conv_ext;
    logic       scan_ext;
    logic       hold_en;
    logic       hold_low;
    logic       ref_fall;
    logic       begin_fall;
    logic       trig_en;
    aate_mode_t mode;
  } aate_ctrl_t;

  // terminal selects, one nibble per function
  typedef struct packed {
    logic [3:0] scan_tb;
    logic [3:0] conv;
    logic [3:0] scan;
    logic [3:0] hold;
    logic [3:0] refr;
    logic [3:0] begin_src;
  } aate_src_t;

endpackage

// ===== core/aate_term_sync.sv
`timescale 1ns/1ps
module aate_term_sync
  import aate_pkg::*;
#(
  parameter int N = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] din,
  output logic      [N-1:0] lvl,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
  } aate_sync_st_t;

  aate_sync_st_t r;
  aate_sync_st_t r_nxt;

  // at least one terminal
  if (N < 1) begin : g_bad_param
    $error("aate_term_sync: unsupported parameter values");
  end

  // s1 feeds only s2; s3 holds the previous settled level for edge detection
  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = din;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // one event per edge, single cycle [R23]
  for (genvar i = 0; i < N; i++) begin : g_edge
    assign lvl[i]  = r.s2[i];
    assign rise[i] = r.s2[i] & ~r.s3[i];
    assign fall[i] = ~r.s2[i] & r.s3[i];
  end

endmodule

// ===== core/aate_sample_mem.sv
`timescale 1ns/1ps
module aate_sample_mem
  import aate_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 1024
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [W-1:0]             wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [W-1:0]             rdata
);

  logic [W-1:0] mem [DEPTH];

  // an address needs at least one bit
  if (DEPTH < 2 || W < 1) begin : g_bad_param
    $error("aate_sample_mem: unsupported parameter values");
  end

  // no reset on the array; contents are only meaningful once written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ===== core/aate_engine.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// R1: routed conversion pulse is driven active low.
// R2: programmable delay from scan pulse to first conversion, reset value three ticks.
// R3: scan and conversion pulses ignored until acquisition has started.
// R4: after an accepted scan pulse, further scan pulses ignored until scan completes.
// R5: conversion pulses before an accepted scan pulse are discarded.
// R6: conversion pulses beyond channel count ignored until next scan pulse.
// R7: single external clock mode converts once per clock tick.
// R8: conversion ticks from scan timebase or 20 MHz timebase, never driven out.
// R9: conversion-started strobe after each conversion, selectable polarity, routable.
// R10: start on begin trigger from selected terminal, or on software go.
// R11: end by sample count, by reference trigger, or by software stop.
// R12: software selects rising or falling edge of begin trigger.
// R13: routed begin trigger is an active high pulse.
// R14: posttrigger count equals buffer size minus pretrigger count.
// R15: reference trigger watched only after pretrigger samples are captured.
// R16: full buffer while armed overwrites oldest stored sample.
// R17: after reference trigger store posttrigger samples, then stop.
// R18: software selects rising or falling edge of reference trigger.
// R19: pause input halts internal scan clock, active level programmable.
// R20: pause is level sensitive, routed out only to trigger bus.
// R21: conversion divider starts on scan pulse, reloads each pulse and after scan.
// R22: conversions per scan equal the channel count.
// R23: external inputs synchronised, edges give single-cycle events.
module aate_engine
  import aate_pkg::*;
#(
  parameter int NTERM = 16,
  parameter int DEPTH = 1024,
  parameter int ADC_W = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [AATE_PADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [NTERM-1:0]        prog_func_pin,
  input  wire logic [ADC_W-1:0]        adc_data,
  input  wire logic                    adc_data_valid,
  output logic                         adc_start,
  output logic                         adc_convert_pulse_n,
  output logic      [7:0]              mux_chan,
  output logic                         conversion_started_strobe,
  output logic                         acq_begin_trig,
  output logic                         acq_hold_gate,
  output logic                         acq_active
);

  localparam int AW = $clog2(DEPTH);

  if (NTERM < 1 || NTERM > 16 || DEPTH < 2 || AW > 16 || (1 << AW) != DEPTH ||
      ADC_W < 1 || ADC_W > 32) begin : g_bad_param
    $error("aate_engine: unsupported parameter values");
  end

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    aate_ctrl_t    ctrl;
    aate_src_t     src;
    logic [15:0]   scan_div;
    logic [15:0]   conv_div;
    logic [15:0]   first_dly;
    logic [15:0]   buf_n;
    logic [15:0]   pre_n;
    logic [7:0]    chan;
    logic [AW-1:0] rd_idx;
    logic [AW-1:0] wptr;
    logic [AW-1:0] ref_pos;
    aate_acq_st_t  acq;
    aate_scan_st_t sc;
    logic          done;
    logic [15:0]   cnt_smp;
    logic [15:0]   fill;
    logic [15:0]   scan_cnt;
    logic [15:0]   div_cnt;
    logic [7:0]    conv_n;
    logic [7:0]    pend;
    logic [3:0]    tb_cnt;
    logic          adc_start;
    logic          conv_out_n;
    logic          strobe;
    logic          begin_out;
    logic          hold_out;
    logic          active;
    logic [7:0]    mux;
  } aate_st_t;

  localparam aate_st_t ST_RST = '{
    ctrl:       '0,
    src:        '0,
    scan_div:   AATE_SCAN_DIV_RST,
    conv_div:   AATE_CONV_DIV_RST,
    first_dly:  AATE_FIRST_DLY_RST,
    buf_n:      AATE_BUF_SIZE_RST,
    pre_n:      AATE_PRE_CNT_RST,
    chan:       AATE_CHAN_RST,
    acq:        ACQ_IDLE,
    sc:         SC_WAIT,
    conv_out_n: 1'b1,
    default:    '0
  };

  aate_st_t r;
  aate_st_t r_nxt;

  logic [NTERM-1:0] s_lvl;
  logic [NTERM-1:0] s_rise;
  logic [NTERM-1:0] s_fall;
  logic [15:0]      t_lvl;
  logic [15:0]      t_rise;
  logic [15:0]      t_fall;
  logic [ADC_W-1:0] mem_q;
  logic             store;
  logic [23:0]      buf_words;
  logic [AW-1:0]    wrap_at;
  logic [7:0]       chan_eff;

  // all external sources pass a synchroniser before any decision [R23]
  aate_term_sync #(.N(NTERM)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (prog_func_pin),
    .lvl   (s_lvl),
    .rise  (s_rise),
    .fall  (s_fall)
  );

  aate_sample_mem #(.W(ADC_W), .DEPTH(DEPTH)) u_mem (
    .clk   (pclk),
    .we    (store),
    .waddr (r.wptr),
    .wdata (adc_data),
    .raddr (r.rd_idx),
    .rdata (mem_q)
  );

  // widen to the 16 selectable terminals; selects past NTERM read low
  assign t_lvl  = 16'(s_lvl);
  assign t_rise = 16'(s_rise);
  assign t_fall = 16'(s_fall);

  // data is stored only for conversions this block started
  assign store     = adc_data_valid & (r.pend != 8'h00);
  assign chan_eff  = (r.chan == 8'h00) ? 8'h01 : r.chan;
  assign buf_words = r.buf_n * chan_eff;
  // ring length in words; a request larger than the memory is clipped to it
  assign wrap_at   = (buf_words == 24'h000000 || buf_words > 24'(DEPTH)) ?
                     AW'(DEPTH - 1) : AW'(buf_words - 24'h000001);

  // next state: bus slave, timebases, scan engine, acquisition sequencer
  always_comb begin
    logic        prep;
    logic        acc;
    logic        go;
    logic        stop;
    logic        tb_tick;
    logic        scan_tick;
    logic        conv_tick;
    logic        acquiring;
    logic        paused;
    logic        int_scan;
    logic        ext_scan;
    logic        ext_conv;
    logic        scan_req;
    logic        accept;
    logic        fire;
    logic        sd;
    logic        start;
    logic        finish;
    logic        begin_edge;
    logic        ref_edge;
    logic [7:0]  idx;
    logic [15:0] post_n;
    prep       = 1'b0;
    acc        = 1'b0;
    go         = 1'b0;
    stop       = 1'b0;
    tb_tick    = 1'b0;
    scan_tick  = 1'b0;
    conv_tick  = 1'b0;
    acquiring  = 1'b0;
    paused     = 1'b0;
    int_scan   = 1'b0;
    ext_scan   = 1'b0;
    ext_conv   = 1'b0;
    scan_req   = 1'b0;
    accept     = 1'b0;
    fire       = 1'b0;
    sd         = 1'b0;
    start      = 1'b0;
    finish     = 1'b0;
    begin_edge = 1'b0;
    ref_edge   = 1'b0;
    idx        = 8'h00;
    post_n     = 16'h0000;
    r_nxt      = r;
    r_nxt.adc_start  = 1'b0;
    r_nxt.conv_out_n = 1'b1;
    r_nxt.begin_out  = 1'b0;

    // apb: one wait state, read data and error prepared in the first access cycle
    prep          = psel & penable & ~r.pready;
    acc           = psel & penable & r.pready;
    r_nxt.pready  = prep;
    r_nxt.pslverr = 1'b0;
    if (prep) begin
      if (paddr == AATE_OFF_CTRL) begin
        r_nxt.prdata = 32'({r.ctrl, 2'b00});
      end else if (paddr == AATE_OFF_SRC) begin
        r_nxt.prdata = 32'(r.src);
      end else if (paddr == AATE_OFF_SCAN_DIV) begin
        r_nxt.prdata = 32'(r.scan_div);
      end else if (paddr == AATE_OFF_CONV_DIV) begin
        r_nxt.prdata = {r.first_dly, r.conv_div};
      end else if (paddr == AATE_OFF_CHAN) begin
        r_nxt.prdata = 32'(r.chan);
      end else if (paddr == AATE_OFF_BUF_SIZE) begin
        r_nxt.prdata = 32'(r.buf_n);
      end else if (paddr == AATE_OFF_PRE_CNT) begin
        r_nxt.prdata = 32'(r.pre_n);
      end else if (paddr == AATE_OFF_STATUS) begin
        r_nxt.prdata = {r.fill, 9'h000, r.hold_out, r.done, r.sc, r.acq};
      end else if (paddr == AATE_OFF_RD_IDX) begin
        r_nxt.prdata = 32'(r.rd_idx);
      end else if (paddr == AATE_OFF_RD_DATA) begin
        r_nxt.prdata = 32'(mem_q);
      end else if (paddr == AATE_OFF_WPTR) begin
        r_nxt.prdata = {16'(r.ref_pos), 16'(r.wptr)};
      end else begin
        r_nxt.prdata  = 32'h00000000;
        r_nxt.pslverr = 1'b1;
      end
    end

    // writes land on the edge that completes the transfer
    if (acc & pwrite) begin
      if (paddr == AATE_OFF_CTRL) begin
        r_nxt.ctrl = aate_ctrl_t'(pwdata[AATE_CTRL_MSB:AATE_CTRL_LSB]);
        go         = pwdata[AATE_CTRL_GO_BIT];
        stop       = pwdata[AATE_CTRL_STOP_BIT];
      end else if (paddr == AATE_OFF_SRC) begin
        r_nxt.src = aate_src_t'(pwdata[AATE_SRC_MSB:0]);
      end else if (paddr == AATE_OFF_SCAN_DIV) begin
        r_nxt.scan_div = pwdata[15:0];
      end else if (paddr == AATE_OFF_CONV_DIV) begin
        r_nxt.conv_div  = pwdata[15:0];
        r_nxt.first_dly = pwdata[31:AATE_FIRST_DLY_LSB];
      end else if (paddr == AATE_OFF_CHAN) begin
        r_nxt.chan = pwdata[7:0];
      end else if (paddr == AATE_OFF_BUF_SIZE) begin
        r_nxt.buf_n = pwdata[15:0];
      end else if (paddr == AATE_OFF_PRE_CNT) begin
        r_nxt.pre_n = pwdata[15:0];
      end else if (paddr == AATE_OFF_RD_IDX) begin
        r_nxt.rd_idx = pwdata[AW-1:0];
      end
    end else if (acc & (paddr == AATE_OFF_RD_DATA)) begin
      // reading the data word steps the read index for block reads
      r_nxt.rd_idx = r.rd_idx + AW'(1);
    end

    // 20 MHz tick; the conversion timebase stays internal [R8]
    tb_tick      = (r.tb_cnt == AATE_TB_CNT_MAX);
    r_nxt.tb_cnt = tb_tick ? 4'h0 : r.tb_cnt + 4'h1;
    scan_tick    = r.ctrl.scan_tb_ext ? t_rise[r.src.scan_tb] : tb_tick;
    conv_tick    = r.ctrl.conv_tb_scan ? scan_tick : tb_tick; // [R8]

    acquiring = (r.acq == ACQ_RUN) | (r.acq == ACQ_PRE) |
                (r.acq == ACQ_ARMED) | (r.acq == ACQ_POST);
    // level compare only, no edge involved [R20]
    paused    = r.ctrl.hold_en & (t_lvl[r.src.hold] ^ r.ctrl.hold_low);

    // internal scan divider freezes while paused [R19]
    if (acquiring & ~paused & scan_tick) begin
      if (r.scan_cnt <= 16'h0001) begin
        int_scan       = 1'b1;
        r_nxt.scan_cnt = r.scan_div;
      end else begin
        r_nxt.scan_cnt = r.scan_cnt - 16'h0001;
      end
    end

    ext_scan = t_rise[r.src.scan];
    ext_conv = t_rise[r.src.conv];
    // in single clock mode the one source is both scan and conversion [R7]
    scan_req = r.ctrl.single_clk ? ext_conv : (r.ctrl.scan_ext ? ext_scan : int_scan);

    // scan engine; nothing passes outside an acquisition [R3]
    if (!acquiring) begin
      r_nxt.sc      = SC_WAIT;
      r_nxt.div_cnt = r.first_dly;
    end else begin
      case (r.sc)
        SC_WAIT: begin
          // outside single clock mode, conversion pulses here are dropped [R5] [R6]
          if (scan_req) begin
            accept       = 1'b1;
            r_nxt.conv_n = 8'h00;
            r_nxt.mux    = 8'h00;
            if (r.ctrl.single_clk) begin
              fire = 1'b1; // [R7]
            end else if (r.ctrl.conv_ext) begin
              r_nxt.sc = SC_CONV;
            end else begin
              r_nxt.sc      = SC_DELAY;
              r_nxt.div_cnt = r.first_dly; // [R2]
            end
          end
        end
        SC_DELAY: begin
          // first conversion after first_dly ticks [R2]
          if (conv_tick) begin
            if (r.div_cnt <= 16'h0001) begin
              fire          = 1'b1;
              r_nxt.div_cnt = r.conv_div;
            end else begin
              r_nxt.div_cnt = r.div_cnt - 16'h0001;
            end
          end
        end
        SC_CONV: begin
          // scan pulses are not looked at while converting [R4]
          if (r.ctrl.conv_ext | r.ctrl.single_clk) begin
            fire = ext_conv;
          end else if (conv_tick) begin
            if (r.div_cnt <= 16'h0001) begin
              fire          = 1'b1;
              r_nxt.div_cnt = r.conv_div; // [R21]
            end else begin
              r_nxt.div_cnt = r.div_cnt - 16'h0001;
            end
          end
        end
        default: begin
          r_nxt.sc = SC_WAIT;
        end
      endcase
    end

    // each conversion but the last steps the channel; the last one closes the scan [R22]
    if (fire) begin
      idx              = accept ? 8'h00 : r.conv_n;
      r_nxt.adc_start  = 1'b1;
      r_nxt.conv_out_n = ~r.ctrl.route_conv; // [R1]
      if (idx + 8'h01 >= chan_eff) begin
        sd            = 1'b1;
        r_nxt.sc      = SC_WAIT;
        r_nxt.conv_n  = 8'h00;
        r_nxt.div_cnt = r.first_dly; // [R21]
      end else begin
        r_nxt.sc     = SC_CONV;
        r_nxt.conv_n = idx + 8'h01;
        r_nxt.mux    = idx + 8'h01;
      end
    end

    // strobe follows the conversion start by one cycle [R9]
    r_nxt.strobe = r.ctrl.route_strobe ? (r.adc_start ^ r.ctrl.strobe_low) : r.ctrl.strobe_low;

    // outstanding conversions and ring write pointer [R16]
    r_nxt.pend = r.pend + {7'h00, fire} - {7'h00, store};
    if (store) begin
      r_nxt.wptr = (r.wptr == wrap_at) ? '0 : r.wptr + AW'(1);
    end
    if (sd & (r.fill < r.buf_n)) begin
      r_nxt.fill = r.fill + 16'h0001;
    end

    begin_edge = r.ctrl.begin_fall ? t_fall[r.src.begin_src] : t_rise[r.src.begin_src]; // [R12]
    ref_edge   = r.ctrl.ref_fall ? t_fall[r.src.refr] : t_rise[r.src.refr]; // [R18]

    // acquisition sequencer
    case (r.acq)
      ACQ_IDLE: begin
        if (go) begin
          if (r_nxt.ctrl.trig_en) begin
            r_nxt.acq = ACQ_WAIT_BEGIN;
          end else begin
            start = 1'b1; // [R10]
          end
        end
      end
      ACQ_WAIT_BEGIN: begin
        start = begin_edge; // [R10]
      end
      ACQ_RUN: begin
        if (sd & (r.ctrl.mode == AATE_MODE_FINITE)) begin
          if (r.cnt_smp <= 16'h0001) begin
            finish = 1'b1; // [R11]
          end else begin
            r_nxt.cnt_smp = r.cnt_smp - 16'h0001;
          end
        end
      end
      ACQ_PRE: begin
        // reference edges are not looked at here [R15]
        if (sd) begin
          if (r.cnt_smp <= 16'h0001) begin
            r_nxt.acq = ACQ_ARMED;
          end else begin
            r_nxt.cnt_smp = r.cnt_smp - 16'h0001;
          end
        end
      end
      ACQ_ARMED: begin
        if (ref_edge) begin
          post_n        = r.buf_n - r.pre_n; // [R14]
          r_nxt.ref_pos = r.wptr;
          if (post_n == 16'h0000 || r.pre_n > r.buf_n) begin
            finish = 1'b1;
          end else begin
            r_nxt.acq     = ACQ_POST;
            r_nxt.cnt_smp = post_n;
          end
        end
      end
      ACQ_POST: begin
        if (sd) begin
          if (r.cnt_smp <= 16'h0001) begin
            finish = 1'b1; // [R17]
          end else begin
            r_nxt.cnt_smp = r.cnt_smp - 16'h0001;
          end
        end
      end
      default: begin
        r_nxt.acq = ACQ_IDLE;
      end
    endcase

    if (start) begin
      r_nxt.done      = 1'b0;
      r_nxt.wptr      = '0;
      r_nxt.fill      = 16'h0000;
      r_nxt.scan_cnt  = r_nxt.scan_div;
      r_nxt.begin_out = r_nxt.ctrl.route_begin; // [R13]
      if (r_nxt.ctrl.mode == AATE_MODE_REF) begin
        r_nxt.acq     = (r_nxt.pre_n == 16'h0000) ? ACQ_ARMED : ACQ_PRE; // [R15]
        r_nxt.cnt_smp = r_nxt.pre_n;
      end else begin
        r_nxt.acq     = ACQ_RUN;
        r_nxt.cnt_smp = r_nxt.buf_n;
      end
    end

    // software stop ends any mode, a stray go while busy is ignored [R11]
    if (finish | (stop & (r.acq != ACQ_IDLE))) begin
      r_nxt.acq  = ACQ_IDLE;
      r_nxt.done = 1'b1;
    end

    r_nxt.hold_out = r.ctrl.route_hold & paused; // [R20]
    r_nxt.active   = (r_nxt.acq == ACQ_RUN) | (r_nxt.acq == ACQ_PRE) |
                     (r_nxt.acq == ACQ_ARMED) | (r_nxt.acq == ACQ_POST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= ST_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // every output is a state bit
  assign prdata                    = r.prdata;
  assign pready                    = r.pready;
  assign pslverr                   = r.pslverr;
  assign adc_start                 = r.adc_start;
  assign adc_convert_pulse_n       = r.conv_out_n;
  assign mux_chan                  = r.mux;
  assign conversion_started_strobe = r.strobe;
  assign acq_begin_trig            = r.begin_out;
  assign acq_hold_gate             = r.hold_out;
  assign acq_active                = r.active;

endmodule

// ===== dv/aate_adc_model.sv
`timescale 1ns/1ps
module aate_adc_model (
  input  wire logic        pclk,
  input  wire logic        adc_start,
  output logic             adc_data_valid,
  output logic      [15:0] adc_data
);
  // a word one cycle after each start; the bus keeps moving so old data never looks fresh
  initial begin
    adc_data_valid = 1'h0;
    adc_data       = 16'h0000;
  end
  always @(posedge pclk) begin
    adc_data_valid <= adc_start;
    adc_data       <= adc_data + 16'h1111;
  end
endmodule

// ===== dv/aate_engine_checker.sv
`timescale 1ns/1ps
module aate_engine_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_start,
  input wire logic adc_convert_pulse_n,
  input wire logic conversion_started_strobe,
  input wire logic acq_begin_trig,
  input wire logic acq_active
);
  // one domain; reset silences every check
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_cnv_lo; !adc_convert_pulse_n |-> adc_start; endproperty
  a_cnv_lo: assert property (p_cnv_lo) else $error("convert low alone");
  property p_cnv_pw; !adc_convert_pulse_n |=> adc_convert_pulse_n; endproperty
  a_cnv_pw: assert property (p_cnv_pw) else $error("convert too long");
  property p_gate; !acq_active && !$past(acq_active) |-> !adc_start; endproperty
  a_gate: assert property (p_gate) else $error("convert while idle");
  property p_beg; acq_begin_trig |-> $rose(acq_active); endproperty
  a_beg: assert property (p_beg) else $error("begin pulse off start");
  property p_beg_pw; acq_begin_trig |=> !acq_begin_trig; endproperty
  a_beg_pw: assert property (p_beg_pw) else $error("begin pulse too long");
  property p_st_pw; adc_start |=> !adc_start; endproperty
  a_st_pw: assert property (p_st_pw) else $error("start too long");
  property p_stb; acq_active && $past(acq_active, 3) && $changed(conversion_started_strobe)
    |-> $past(adc_start) || $past(adc_start, 2); endproperty
  a_stb: assert property (p_stb) else $error("strobe without convert");
  property p_end; $fell(acq_active) |=> !adc_start; endproperty
  a_end: assert property (p_end) else $error("convert after end");
endmodule
bind aate_engine aate_engine_checker u_chk (.*);

// ===== dv/aate_engine_bench.sv
`timescale 1ns/1ps
module aate_engine_bench
  import aate_pkg::*;
;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        pready, pslverr, adc_data_valid, adc_start, adc_convert_pulse_n, acq_active;
  logic        conversion_started_strobe, acq_begin_trig, acq_hold_gate;
  logic [7:0]  paddr = 8'h00, mux_chan;
  logic [15:0] prog_func_pin = 16'h0000, adc_data;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int          err_total = 0, checks = 0, nconv = 0;
  time         tc[$];
  // 40 MHz clock, parts
  always #12.5 pclk = ~pclk;
  aate_engine u_dut (.*);
  aate_adc_model u_adc (.*);
  // log each conversion start
  always @(posedge pclk) begin
    if (adc_start === 1'h1) begin
      nconv++;
      tc.push_back($time);
    end
  end
  // verdict, then stop
  task automatic conclude();
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  // apb transfer, held until pready; only the watchdog ends the wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pulse(input int p);
    prog_func_pin[p] <= 1'h1;
    repeat (4) @(posedge pclk);
    prog_func_pin[p] <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask
  // finite, internal timebase: two channels, two samples; pin 0 pauses the scan divider first
  task automatic t_fin();
    prog_func_pin[0] <= 1'h1;
    xfer(1'h0, AATE_OFF_CONV_DIV, 32'h0);
    chk(q, 32'h00030002);
    xfer(1'h1, AATE_OFF_CHAN, 32'h2);
    xfer(1'h1, AATE_OFF_BUF_SIZE, 32'h2);
    xfer(1'h1, AATE_OFF_CTRL, 32'h78105);
    repeat (60) @(posedge pclk);
    chk(nconv, 32'h0);
    chk(32'(acq_hold_gate), 32'h1);
    prog_func_pin[0] <= 1'h0;
    wait (acq_active === 1'h0);
    // let the logger see the last start before counting
    repeat (2) @(posedge pclk);
    chk(nconv, 32'h4);
    chk(32'((tc[1] - tc[0]) / 25), 32'h4);
  endtask
  // pin 1 clocks scan and conversion alike
  task automatic t_one();
    xfer(1'h1, AATE_OFF_SRC, 32'h11000);
    nconv = 0;
    repeat (2) pulse(1);
    chk(nconv, 32'h0);
    xfer(1'h1, AATE_OFF_CTRL, 32'h38e01);
    repeat (5) pulse(1);
    chk(nconv, 32'h5);
    chk(32'(mux_chan), 32'h1);
    xfer(1'h1, AATE_OFF_CTRL, 32'h38e02);
    pulse(1);
    chk(nconv, 32'h5);
    // scan on pin 1, conversions on pin 2: early, repeated and surplus pulses dropped
    xfer(1'h1, AATE_OFF_SRC, 32'h21000);
    xfer(1'h1, AATE_OFF_CTRL, 32'h38601);
    nconv = 0;
    pulse(2);
    pulse(1);
    pulse(2);
    pulse(1);
    pulse(2);
    pulse(2);
    chk(nconv, 32'h2);
    xfer(1'h1, AATE_OFF_CTRL, 32'h38602);
  endtask
  // falling pin 0 begins; early reference dropped; ring wraps; posttrigger kept
  task automatic t_ref();
    xfer(1'h1, AATE_OFF_CHAN, 32'h1);
    xfer(1'h1, AATE_OFF_BUF_SIZE, 32'h4);
    xfer(1'h1, AATE_OFF_PRE_CNT, 32'h2);
    xfer(1'h1, AATE_OFF_SRC, 32'h20);
    xfer(1'h1, AATE_OFF_CTRL, 32'h38039);
    prog_func_pin[0] <= 1'h1;
    repeat (8) @(posedge pclk);
    chk(32'(acq_active), 32'h0);
    prog_func_pin[0] <= 1'h0;
    repeat (8) @(posedge pclk);
    pulse(2);
    xfer(1'h0, AATE_OFF_STATUS, 32'h0);
    chk(32'(q[2:0]), 32'h3);
    // eight stores wrap the ring twice; the reference lands well clear of any store
    repeat (8) do @(posedge pclk); while (adc_start !== 1'h1);
    repeat (10) @(posedge pclk);
    pulse(2);
    wait (acq_active === 1'h0);
    repeat (4) @(posedge pclk);
    xfer(1'h0, AATE_OFF_WPTR, 32'h0);
    chk(32'(q[15:0] - q[31:16]) & 32'h3, 32'h2);
  endtask
  // reset, then the scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_fin();
    t_one();
    t_ref();
    conclude();
  end
  // hang guard, far past the expected run
  initial begin
    #500000;
    err_total++;
    conclude();
  end
endmodule
